// ### logic/trbg_cfg.svh
`ifndef TRBG_CFG_SVH
`define TRBG_CFG_SVH
// ==========================================================
// register offsets
`define TRBG_OFF_START 12'h000
`define TRBG_OFF_STOP 12'h004
`define TRBG_OFF_READY 12'h100
`define TRBG_OFF_LINKS 12'h200
`define TRBG_OFF_IRQ_SET 12'h304
`define TRBG_OFF_IRQ_CLR 12'h308
`define TRBG_OFF_CONFIG 12'h504
`define TRBG_OFF_VALUE 12'h508
// ==========================================================
// field positions and reset values
`define TRBG_BIT_TRIGGER 0
`define TRBG_BIT_READY 0
`define TRBG_BIT_HALT_LINK 0
`define TRBG_BIT_IRQ 0
`define TRBG_BIT_BIAS 0
`define TRBG_RST_REG 1'b0
`define TRBG_RST_VALUE 8'h00
// ==========================================================
// timing
`define TRBG_STARTUP_US 128
`define TRBG_CLK_MHZ 100
`define TRBG_STARTUP_CYC (`TRBG_STARTUP_US * `TRBG_CLK_MHZ)
`endif

// ### logic/trbg_pkg.sv
package trbg_pkg;
  typedef enum logic [1:0] {
    TRBG_IDLE = 2'b00,
    TRBG_WARM = 2'b01,
    TRBG_RUN = 2'b10
  } trbg_state_t;
endpackage

// ### logic/trbg_random_source_unit.sv
`timescale 1ns/1ps
`include "trbg_cfg.svh"
// Functional notes
// - writing one to start trigger puts generator into running state
// - writing one to stop trigger leaves running state, no more bytes
// - while running, bytes produced continuously, stored when complete
// - ready flag set once per new byte written to output
// - new byte overwrites previous output, no holding buffer
// - bias correction removes one/zero preference before packing
// - processed bits shift into eight-bit register, read in parallel
// - config register selects bias correction, slower uniform output
// - byte time varies, more with bias correction
// - no software seed; randomness only from noise input
// - output at 0x508, interrupt enable set/clear at 0x304/0x308
// - links register at 0x200 holds event-to-task shortcut enables
// - ready-to-halt link stops generator after each ready event
// - set/clear bit 0 enables/disables interrupt; both read enable
// - config bit 0 selects bias; output read-only 0..255
// - first byte only after one-time 128 us start-up delay
module trbg_random_source_unit
  import trbg_pkg::*;
#(
  parameter int STARTUP_CYC = `TRBG_STARTUP_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic noise_bit,
  input wire logic noise_valid,
  output logic irq
);

  // ==========================================================
  // noise input synchronisers
  logic noise_bit_s1;
  logic noise_bit_s2;
  logic noise_valid_s1;
  logic noise_valid_s2;
  logic noise_valid_s3;
  logic noise_strobe;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      noise_bit_s1 <= 1'b0;
      noise_bit_s2 <= 1'b0;
      noise_valid_s1 <= 1'b0;
      noise_valid_s2 <= 1'b0;
      noise_valid_s3 <= 1'b0;
    end
    else if (clk_en)
    begin
      noise_bit_s1 <= noise_bit;
      noise_bit_s2 <= noise_bit_s1;
      noise_valid_s1 <= noise_valid;
      noise_valid_s2 <= noise_valid_s1;
      noise_valid_s3 <= noise_valid_s2;
    end
  end

  // strobe is a level toggle-free pulse: rising edge of synchronised valid
  assign noise_strobe = noise_valid_s2 & ~noise_valid_s3;

  // ==========================================================
  // bus decode
  logic bus_wr;
  logic bus_rd;
  logic wr_lane0;
  logic start_hit;
  logic stop_hit;
  logic ready_wr;
  logic [31:0] next_readdata;

  // single-cycle wait: request accepted on the cycle waitrequest is low
  assign bus_wr = avs_write & ~avs_waitrequest & clk_en;
  assign bus_rd = avs_read & ~avs_waitrequest & clk_en;
  assign wr_lane0 = bus_wr & avs_byteenable[0];
  assign start_hit = wr_lane0 && avs_address == `TRBG_OFF_START
    && avs_writedata[`TRBG_BIT_TRIGGER];
  assign stop_hit = wr_lane0 && avs_address == `TRBG_OFF_STOP
    && avs_writedata[`TRBG_BIT_TRIGGER];
  assign ready_wr = wr_lane0 && avs_address == `TRBG_OFF_READY;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (clk_en)
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
  end

  // ==========================================================
  // control registers
  logic halt_link;
  logic irq_en;
  logic bias_en;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      halt_link <= `TRBG_RST_REG;
    else if (wr_lane0 && avs_address == `TRBG_OFF_LINKS)
      halt_link <= avs_writedata[`TRBG_BIT_HALT_LINK];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_en <= `TRBG_RST_REG;
    else if (wr_lane0 && avs_address == `TRBG_OFF_IRQ_SET && avs_writedata[`TRBG_BIT_IRQ])
      irq_en <= 1'b1;
    else if (wr_lane0 && avs_address == `TRBG_OFF_IRQ_CLR && avs_writedata[`TRBG_BIT_IRQ])
      irq_en <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      bias_en <= `TRBG_RST_REG;
    else if (wr_lane0 && avs_address == `TRBG_OFF_CONFIG)
      bias_en <= avs_writedata[`TRBG_BIT_BIAS];
  end

  // ==========================================================
  // run state machine
  trbg_state_t state;
  trbg_state_t next_state;
  logic [$clog2(STARTUP_CYC+1)-1:0] warm_cnt;
  logic byte_done;
  logic auto_stop;

  assign auto_stop = byte_done & halt_link;

  always_comb
  begin
    next_state = state;
    case (state)
      TRBG_IDLE:
        if (start_hit)
          next_state = TRBG_WARM;
      TRBG_WARM:
        if (stop_hit)
          next_state = TRBG_IDLE;
        else if (warm_cnt == '0)
          next_state = TRBG_RUN;
      TRBG_RUN:
        if (stop_hit || auto_stop)
          next_state = TRBG_IDLE;
      default:
        next_state = TRBG_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= TRBG_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // delay spent once per start, never between bytes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      warm_cnt <= '0;
    else if (clk_en)
    begin
      if (state == TRBG_IDLE && start_hit)
        warm_cnt <= ($clog2(STARTUP_CYC+1))'(STARTUP_CYC - 1);
      else if (state == TRBG_WARM && warm_cnt != '0)
        warm_cnt <= warm_cnt - 1'b1;
    end
  end

  // ==========================================================
  // bias correction: von Neumann pairs, 01 -> 0, 10 -> 1, equal dropped
  logic pair_half;
  logic pair_first;
  logic bit_take;
  logic bit_val;
  logic running;

  assign running = state == TRBG_RUN;

  always_comb
  begin
    bit_take = 1'b0;
    bit_val = noise_bit_s2;
    if (running && noise_strobe)
    begin
      if (!bias_en)
        bit_take = 1'b1;
      else if (pair_half && pair_first != noise_bit_s2)
      begin
        bit_take = 1'b1;
        bit_val = pair_first;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pair_half <= 1'b0;
      pair_first <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!running || !bias_en)
        pair_half <= 1'b0;
      else if (noise_strobe)
      begin
        pair_half <= ~pair_half;
        pair_first <= noise_bit_s2;
      end
    end
  end

  // ==========================================================
  // byte packing and output
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [7:0] value;
  logic [7:0] next_shift;

  assign next_shift = {shift[6:0], bit_val};
  assign byte_done = clk_en & bit_take & (bit_cnt == 3'h7);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift <= 8'h00;
      bit_cnt <= 3'h0;
    end
    else if (clk_en)
    begin
      if (!running)
        bit_cnt <= 3'h0;
      else if (bit_take)
      begin
        shift <= next_shift;
        bit_cnt <= bit_cnt + 3'h1;
      end
    end
  end

  // straight overwrite, software must read before the next event
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      value <= `TRBG_RST_VALUE;
    else if (byte_done)
      value <= next_shift;
  end

  // ==========================================================
  // event flag and interrupt
  logic ready_flag;

  // set wins over a clearing write in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ready_flag <= `TRBG_RST_REG;
    else if (byte_done)
      ready_flag <= 1'b1;
    else if (ready_wr)
      ready_flag <= avs_writedata[`TRBG_BIT_READY];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else if (clk_en)
      irq <= ready_flag & irq_en;
  end

  // ==========================================================
  // read path
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `TRBG_OFF_READY: next_readdata[`TRBG_BIT_READY] = ready_flag;
      `TRBG_OFF_LINKS: next_readdata[`TRBG_BIT_HALT_LINK] = halt_link;
      `TRBG_OFF_IRQ_SET: next_readdata[`TRBG_BIT_IRQ] = irq_en;
      `TRBG_OFF_IRQ_CLR: next_readdata[`TRBG_BIT_IRQ] = irq_en;
      `TRBG_OFF_CONFIG: next_readdata[`TRBG_BIT_BIAS] = bias_en;
      `TRBG_OFF_VALUE: next_readdata[7:0] = value;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h0000_0000;
    else if (clk_en && avs_read && avs_waitrequest)
      avs_readdata <= next_readdata;
  end

  // ==========================================================
  // checks
  a_start_warm: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TRBG_IDLE && start_hit) |=> state == TRBG_WARM)
    else $error("start did not enter warm-up");

  a_start_load: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TRBG_IDLE && start_hit) |=> warm_cnt == STARTUP_CYC - 1)
    else $error("warm-up count not loaded on start");

  a_stop_idle: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TRBG_RUN && stop_hit) |=> state == TRBG_IDLE)
    else $error("stop did not halt generator");

  a_stop_warm: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TRBG_WARM && stop_hit) |=> state == TRBG_IDLE)
    else $error("stop during warm-up did not return to idle");

  a_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
    byte_done |=> ready_flag && value == $past(next_shift))
    else $error("byte done without flag or value");

  a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (ready_wr && !byte_done && !avs_writedata[`TRBG_BIT_READY]) |=> !ready_flag)
    else $error("zero write did not clear ready flag");

  // flag and value must stay put while not running and no ready write is made
  a_idle_no_byte: assert property (@(posedge clk) disable iff (sys_rst)
    (!running && !ready_wr) |=> $stable(ready_flag) && $stable(value))
    else $error("byte produced while not running");

  a_halt_once: assert property (@(posedge clk) disable iff (sys_rst)
    (byte_done && halt_link) |=> state == TRBG_IDLE)
    else $error("halt link did not stop");

  a_warm_len: assert property (@(posedge clk) disable iff (sys_rst)
    (state == TRBG_WARM && warm_cnt != '0 && clk_en && !stop_hit)
    |=> state == TRBG_WARM)
    else $error("warm-up ended early");

  // an output bit closes its pair, so the next strobe opens a new one
  a_bias_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (clk_en && bit_take && bias_en) |=> !pair_half)
    else $error("bias correction pairing out of step");

  a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |=> irq == $past(ready_flag && irq_en))
    else $error("irq not matching flag and enable");

  a_irq_disable: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_lane0 && avs_address == `TRBG_OFF_IRQ_CLR && avs_writedata[`TRBG_BIT_IRQ])
    |=> !irq_en)
    else $error("clear write did not disable interrupt");

  a_value_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !byte_done |=> $stable(value))
    else $error("value changed without new byte");

  a_value_ro: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_lane0 && avs_address == `TRBG_OFF_VALUE && !byte_done) |=> $stable(value))
    else $error("bus write changed output value");

endmodule

// ### verif/tb_trbg_random_source_unit.sv
`timescale 1ns/1ps
`include "trbg_cfg.svh"
module tb_trbg_random_source_unit;
  import trbg_pkg::*;
  // short warm-up keeps the run brief
  localparam int STARTUP = 10;
  logic clk;
  logic sys_rst;
  logic clk_en;
  logic [11:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic noise_bit;
  logic noise_valid;
  logic irq;
  int errors = 0;
  int comparisons = 0;
  logic [11:0] zero_regs [7];

  trbg_random_source_unit #(.STARTUP_CYC(STARTUP)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .noise_bit(noise_bit),
    .noise_valid(noise_valid), .irq(irq)
  );

  // ==========================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // the tests need under 2000 cycles; 20000 leaves ample margin
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

  // ==========================================================
  // checks and bus access
  task automatic check_word(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic check_irq(input logic exp);
    comparisons++;
    if (irq !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, irq, exp);
    end
  endtask

  task automatic bus_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    // no local limit: a slave that never answers is caught by the watchdog
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so a following call never re-drives a strobe in this step
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(a, 1'b0, 32'h0, q);
    check_word(q, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================
  // noise source
  task automatic send_bit(input logic b);
    noise_bit <= b;
    @(posedge clk);
    noise_valid <= 1'b1;
    wait_cyc(2);
    noise_valid <= 1'b0;
    @(posedge clk);
    // garbage between strobes must never be taken
    noise_bit <= ~b;
    @(posedge clk);
  endtask

  task automatic send_byte(input logic [7:0] v, input logic bias);
    if (bias)
    begin
      send_bit(1'b1);
      send_bit(1'b1);
    end
    for (int i = 7; i >= 0; i--)
    begin
      send_bit(v[i]);
      if (bias)
        send_bit(~v[i]);
    end
    wait_cyc(12);
  endtask

  task automatic start_run();
    wr(`TRBG_OFF_START, 32'h1);
    wait_cyc(STARTUP + 6);
  endtask

  task report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    noise_bit = 1'b0;
    noise_valid = 1'b0;
    zero_regs = '{`TRBG_OFF_READY, `TRBG_OFF_LINKS, `TRBG_OFF_IRQ_SET,
                  `TRBG_OFF_IRQ_CLR, `TRBG_OFF_CONFIG, `TRBG_OFF_VALUE, 12'h010};
    wait_cyc(3);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (zero_regs[i])
      rd(zero_regs[i], 32'h0);
    wr(12'h010, 32'h1);
    rd(12'h010, 32'h0);
    wr(`TRBG_OFF_VALUE, 32'hff);
    rd(`TRBG_OFF_VALUE, 32'h0);
    // a write with lane 0 off must leave the config alone
    avs_byteenable <= 4'he;
    wr(`TRBG_OFF_CONFIG, 32'h1);
    avs_byteenable <= 4'hf;
    rd(`TRBG_OFF_CONFIG, 32'h0);
    wr(`TRBG_OFF_IRQ_SET, 32'h1);
    rd(`TRBG_OFF_IRQ_CLR, 32'h1);
    start_run();
    send_byte(8'ha5, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'ha5);
    rd(`TRBG_OFF_READY, 32'h1);
    check_irq(1'b1);
    wr(`TRBG_OFF_READY, 32'h0);
    wait_cyc(2);
    check_irq(1'b0);
    // a noise pulse while frozen must not be taken
    clk_en <= 1'b0;
    send_bit(1'b1);
    clk_en <= 1'b1;
    send_byte(8'h3c, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'h3c);
    rd(`TRBG_OFF_READY, 32'h1);
    wr(`TRBG_OFF_IRQ_CLR, 32'h1);
    wait_cyc(2);
    check_irq(1'b0);
    rd(`TRBG_OFF_IRQ_SET, 32'h0);
    wr(`TRBG_OFF_STOP, 32'h1);
    send_byte(8'h11, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'h3c);
    // stop inside the warm-up returns to idle before any byte
    wr(`TRBG_OFF_START, 32'h1);
    wr(`TRBG_OFF_STOP, 32'h1);
    wait_cyc(STARTUP + 6);
    send_byte(8'h22, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'h3c);
    // pairwise correction: one equal pair dropped, then 8 unequal pairs
    wr(`TRBG_OFF_CONFIG, 32'h1);
    rd(`TRBG_OFF_CONFIG, 32'h1);
    start_run();
    send_byte(8'h96, 1'b1);
    rd(`TRBG_OFF_VALUE, 32'h96);
    wr(`TRBG_OFF_STOP, 32'h1);
    wr(`TRBG_OFF_CONFIG, 32'h0);
    wr(`TRBG_OFF_LINKS, 32'h1);
    rd(`TRBG_OFF_LINKS, 32'h1);
    wr(`TRBG_OFF_READY, 32'h0);
    rd(`TRBG_OFF_READY, 32'h0);
    wr(`TRBG_OFF_IRQ_SET, 32'h1);
    start_run();
    send_byte(8'h5a, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'h5a);
    check_irq(1'b1);
    send_byte(8'hff, 1'b0);
    rd(`TRBG_OFF_VALUE, 32'h5a);
    report_and_stop();
  end
endmodule
